// file: rtl/mic_irq_regs.svh
/*
 * Register offsets, field positions, reset values and fixed codes of the
 * interrupt controller.
 * Assumes an 8-bit register port whose byte addresses are the values below.
 */
`ifndef MIC_IRQ_REGS_SVH
`define MIC_IRQ_REGS_SVH

// register offsets
`define MIC_ADDR_CTRL        8'h00
`define MIC_ADDR_OPTION      8'h01
`define MIC_ADDR_PEN1        8'h02
`define MIC_ADDR_PEN2        8'h03
`define MIC_ADDR_PEN3        8'h04
`define MIC_ADDR_PREQ1       8'h05
`define MIC_ADDR_PREQ2       8'h06
`define MIC_ADDR_PREQ3       8'h07
// shadow copies sit in data bank 31, eight bytes from this base
`define MIC_ADDR_SHADOW_BASE 8'hF0
`define MIC_SHADOW_IDX_MASK  8'h07
`define MIC_SHADOW_BASE_MASK 8'hF8

// interrupt_control fields
`define MIC_CTRL_GIE         7
`define MIC_CTRL_PERIPH_GROUP_ENABLE        6
`define MIC_CTRL_T0IE        5
`define MIC_CTRL_EXTIE       4
`define MIC_CTRL_PCIE        3
`define MIC_CTRL_T0IF        2
`define MIC_CTRL_EXTIF       1
`define MIC_CTRL_PCIF        0

// option_config field
`define MIC_OPT_EDGE_POL     6

// implemented bits of the peripheral enable and request pairs
`define MIC_PMASK1           8'hC3
`define MIC_PMASK2           8'h24
`define MIC_PMASK3           8'h03

// status bits 4 and 3 (timeout, powerdown) are not shadowed
`define MIC_STATUS_SAVE_MASK 8'hE7

// reset values
`define MIC_RST_BYTE         8'h00
`define MIC_RST_OPTION       8'hFF

// interrupt vector
`define MIC_VECTOR           15'h0004

`endif

// file: rtl/mic_irq_pkg.sv
/*
 * Types shared by the interrupt controller and its surroundings.
 * Assumes mic_irq_regs.svh supplies the numeric constants.
 */
package mic_irq_pkg;

    // core context that is shadowed on entry and restored on return
    typedef struct packed {
        logic [7:0] pc_high;
        logic [7:0] fsr1_hi;
        logic [7:0] fsr1_lo;
        logic [7:0] fsr0_hi;
        logic [7:0] fsr0_lo;
        logic [7:0] bank;
        logic [7:0] status;
        logic [7:0] wreg;
    } mic_ctx_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } mic_bus_req_t;

    // one-cycle event pulses from the peripherals, same clock
    typedef struct packed {
        logic timer0_ovf;
        logic timer1_gate;
        logic adc_done;
        logic timer2_match;
        logic timer1_ovf;
        logic comparator;
        logic osc_accum;
        logic logic_cell2;
        logic logic_cell1;
    } mic_evt_t;

endpackage

// file: rtl/mic_irq_ctrl.sv
/*
 * Interrupt controller of an 8-bit microcontroller core: source flags,
 * enables, vectoring with fixed latency, shadow context, wake from sleep.
 * Assumes one clock tick per instruction cycle, core-side context and
 * stack handled by the core, peripheral events as one-cycle pulses.
 */
//
// Functional notes
// (R1) synchronous event reaches vector in three cycles
// (R2) async edge reaches vector within five cycles
// (R3) latency ignores instruction length
// (R4) software enables wake sources before sleep
// (R5) wake runs next instruction before vectoring
// (R6) edge polarity selects rising or falling
// (R7) valid edge sets flag, vectors if enabled
// (R8) entry pushes PC, shadows core context
// (R9) return restores context from shadow copies
// (R10) shadows in bank 31, read/write
// (R11) flags set regardless of any enable
// (R12) software clears flags before enabling
// (R13) control bit 7 global enable
// (R14) control bit 6 gates peripheral sources
// (R15) control bits 5,4,3 source enables
// (R16) control bits 2,1 read/write flags
// (R17) bit 0 read-only pin-change summary
// (R18) enable register 1 bit layout
// (R19) request register 1 matching layout
// (R20) enable register 2 bits 5,2
// (R21) request register 2 bits 5,2
// (R22) register pair 3 bits 1,0
// (R23) entry flushes, clears global, loads 0004h
// (R24) return pops, restores, sets global enable
// (R25) reset leaves interrupts disabled
// (R26) request ORs gated pairs; wake skips global
`timescale 1ns/1ps
`include "mic_irq_regs.svh"

module mic_irq_ctrl
    import mic_irq_pkg::*;
#(
    parameter int SHADOW_DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire mic_bus_req_t bus_req,
    output logic [7:0]        bus_rdata,
    input  wire mic_evt_t     evt,
    input  wire logic         ext_pin,
    input  wire logic         pin_change_any,
    input  wire logic         sleep_active,
    input  wire logic         return_from_irq_op,
    input  wire mic_ctx_t     core_ctx,
    output logic              flush_prefetch,
    output logic              stack_push,
    output logic              vector_load,
    output logic [14:0]       vector_addr,
    output logic              stack_pop,
    output logic              ctx_restore,
    output mic_ctx_t          restore_ctx,
    output logic              wake
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0] ctrl_q;
    logic [7:0] option_q;

    logic [7:0] pen1_q;
    logic [7:0] pen2_q;
    logic [7:0] pen3_q;

    logic [7:0] preq1_q;
    logic [7:0] preq2_q;
    logic [7:0] preq3_q;

    logic [7:0] shadow_q [SHADOW_DEPTH];
    logic [7:0] rdata_q;

    logic       take_q;
    logic       ret_q;
    logic       wake_blk_q;

    logic       pin_s1_q;
    logic       pin_s2_q;
    logic       pin_s3_q;
    logic       pin_lvl_q;
    logic       pin_lvl_ok_q;
    logic [2:0] pin_fill_q;

    logic [7:0] preq1_set;
    logic [7:0] preq2_set;
    logic [7:0] preq3_set;
    logic       ext_edge;
    logic       core_req;
    logic       periph_req;
    logic       any_req;
    logic       take_d;
    logic       wr_ctrl;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic wr_hit(input logic [7:0] addr);
        wr_hit = bus_req.wr && (bus_req.addr == addr);
    endfunction

    function automatic logic shadow_hit(input logic [7:0] addr);
        shadow_hit = (addr & `MIC_SHADOW_BASE_MASK) == `MIC_ADDR_SHADOW_BASE;
    endfunction

    function automatic logic [2:0] shadow_idx(input logic [7:0] addr);
        logic [7:0] masked;
        masked = addr & `MIC_SHADOW_IDX_MASK;
        shadow_idx = masked[2:0];
    endfunction

    // one byte of the context, by shadow index
    function automatic logic [7:0] ctx_byte(input mic_ctx_t ctx, input logic [2:0] idx);
        logic [63:0] flat;
        flat = ctx;
        ctx_byte = flat[idx*8 +: 8];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // external edge pin: three stages, accept a level once stages 2 and 3 agree

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= ext_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // stages hold reset zeros until the pin has filled all three
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_fill_q <= '0;
        end else begin
            pin_fill_q <= {pin_fill_q[1:0], 1'b1};
        end
    end

    // first agreed level after reset is taken without an edge,
    // so a pin that idles high does not fake a rising edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_lvl_q    <= 1'b0;
            pin_lvl_ok_q <= 1'b0;
        end else if (pin_fill_q[2] && (pin_s2_q == pin_s3_q)) begin
            pin_lvl_q    <= pin_s3_q;
            pin_lvl_ok_q <= 1'b1;
        end
    end

    always_comb begin
        ext_edge = 1'b0;
        if (pin_lvl_ok_q && (pin_s2_q == pin_s3_q) && (pin_s3_q != pin_lvl_q)) begin
            // rising when polarity set, falling when clear
            ext_edge = (pin_s3_q == option_q[`MIC_OPT_EDGE_POL]); // R6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request combining

    assign preq1_set = {evt.timer1_gate, evt.adc_done, 4'h0, evt.timer2_match, evt.timer1_ovf}; // R19
    assign preq2_set = {2'h0, evt.comparator, 2'h0, evt.osc_accum, 2'h0}; // R21
    assign preq3_set = {6'h00, evt.logic_cell2, evt.logic_cell1}; // R22

    always_comb begin
        core_req = (ctrl_q[`MIC_CTRL_T0IE] & ctrl_q[`MIC_CTRL_T0IF])     // R15
                 | (ctrl_q[`MIC_CTRL_EXTIE] & ctrl_q[`MIC_CTRL_EXTIF])
                 | (ctrl_q[`MIC_CTRL_PCIE] & ctrl_q[`MIC_CTRL_PCIF])
                 | (ctrl_q[`MIC_CTRL_EXTIE] & ext_edge); // R2

        periph_req = ctrl_q[`MIC_CTRL_PERIPH_GROUP_ENABLE]                               // R14
                   & (|(pen1_q & preq1_q) | |(pen2_q & preq2_q) | |(pen3_q & preq3_q));

        any_req = core_req | periph_req; // R26
    end

    // wake ignores the global enable
    assign wake = sleep_active & any_req; // R26

    // vector only with global enable, never while asleep, and not in the
    // first awake cycle so the instruction after sleep runs first
    assign take_d = any_req & ctrl_q[`MIC_CTRL_GIE] & ~sleep_active & ~wake_blk_q & ~take_q; // R13 R5

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wake_blk_q <= 1'b0;
        end else begin
            wake_blk_q <= sleep_active; // R5
        end
    end

    // entry is one cycle after the flag is seen, whatever the core is
    // executing, so latency does not depend on instruction length
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            take_q <= 1'b0;
        end else begin
            take_q <= take_d; // R1 R2 R3
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ret_q <= 1'b0;
        end else begin
            ret_q <= return_from_irq_op; // R24
        end
    end

    assign flush_prefetch = take_q; // R23
    assign stack_push     = take_q; // R8
    assign vector_load    = take_q; // R23
    assign stack_pop      = ret_q; // R24
    assign ctx_restore    = ret_q; // R9

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vector_addr <= 15'h0000;
        end else begin
            vector_addr <= `MIC_VECTOR; // R23
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt_control

    assign wr_ctrl = wr_hit(`MIC_ADDR_CTRL);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `MIC_RST_BYTE; // R25
        end else begin
            // global enable: entry clears, return sets, else software
            if (take_d) begin
                ctrl_q[`MIC_CTRL_GIE] <= 1'b0; // R23
            end else if (ret_q) begin
                ctrl_q[`MIC_CTRL_GIE] <= 1'b1; // R24
            end else if (wr_ctrl) begin
                ctrl_q[`MIC_CTRL_GIE] <= bus_req.wdata[`MIC_CTRL_GIE]; // R13
            end

            if (wr_ctrl) begin
                ctrl_q[`MIC_CTRL_PERIPH_GROUP_ENABLE]  <= bus_req.wdata[`MIC_CTRL_PERIPH_GROUP_ENABLE]; // R14
                ctrl_q[`MIC_CTRL_T0IE]  <= bus_req.wdata[`MIC_CTRL_T0IE]; // R15
                ctrl_q[`MIC_CTRL_EXTIE] <= bus_req.wdata[`MIC_CTRL_EXTIE];
                ctrl_q[`MIC_CTRL_PCIE]  <= bus_req.wdata[`MIC_CTRL_PCIE];
            end

            // set wins over a clearing write in the same cycle
            ctrl_q[`MIC_CTRL_T0IF] <= evt.timer0_ovf                      // R11 R16
                                    | (wr_ctrl ? bus_req.wdata[`MIC_CTRL_T0IF] : ctrl_q[`MIC_CTRL_T0IF]);
            ctrl_q[`MIC_CTRL_EXTIF] <= ext_edge                           // R7 R11 R16
                                     | (wr_ctrl ? bus_req.wdata[`MIC_CTRL_EXTIF] : ctrl_q[`MIC_CTRL_EXTIF]);
            // summary follows the per-pin flags only; writes cannot touch it
            ctrl_q[`MIC_CTRL_PCIF] <= pin_change_any; // R17
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // option_config, enables

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            option_q <= `MIC_RST_OPTION;
        end else if (wr_hit(`MIC_ADDR_OPTION)) begin
            option_q <= bus_req.wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pen1_q <= `MIC_RST_BYTE; // R25
            pen2_q <= `MIC_RST_BYTE;
            pen3_q <= `MIC_RST_BYTE;
        end else if (bus_req.wr) begin
            if (bus_req.addr == `MIC_ADDR_PEN1) begin
                pen1_q <= bus_req.wdata & `MIC_PMASK1; // R18
            end
            if (bus_req.addr == `MIC_ADDR_PEN2) begin
                pen2_q <= bus_req.wdata & `MIC_PMASK2; // R20
            end
            if (bus_req.addr == `MIC_ADDR_PEN3) begin
                pen3_q <= bus_req.wdata & `MIC_PMASK3; // R22
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // peripheral request flags: set wins over a clearing write

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            preq1_q <= `MIC_RST_BYTE;
            preq2_q <= `MIC_RST_BYTE;
            preq3_q <= `MIC_RST_BYTE;
        end else begin
            preq1_q <= `MIC_PMASK1 & (preq1_set                           // R11 R19
                     | (wr_hit(`MIC_ADDR_PREQ1) ? bus_req.wdata : preq1_q));
            preq2_q <= `MIC_PMASK2 & (preq2_set                           // R21
                     | (wr_hit(`MIC_ADDR_PREQ2) ? bus_req.wdata : preq2_q));
            preq3_q <= `MIC_PMASK3 & (preq3_set                           // R22
                     | (wr_hit(`MIC_ADDR_PREQ3) ? bus_req.wdata : preq3_q));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shadow copies: captured on entry, writable by software in between

    for (genvar i = 0; i < SHADOW_DEPTH; i++) begin : g_shadow
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                shadow_q[i] <= `MIC_RST_BYTE;
            end else if (take_q) begin
                // status loses timeout and powerdown, they stay live
                if (i == 1) begin
                    shadow_q[i] <= core_ctx.status & `MIC_STATUS_SAVE_MASK; // R8
                end else begin
                    shadow_q[i] <= ctx_byte(core_ctx, 3'(i)); // R8
                end
            end else if (bus_req.wr && shadow_hit(bus_req.addr)
                         && (shadow_idx(bus_req.addr) == 3'(i))) begin
                shadow_q[i] <= bus_req.wdata; // R10
            end
        end
    end

    // restore image stands steady; the core samples it on ctx_restore
    assign restore_ctx = {shadow_q[7], shadow_q[6], shadow_q[5], shadow_q[4], // R9
                          shadow_q[3], shadow_q[2], shadow_q[1], shadow_q[0]};

    ////////////////////////////////////////////////////////////////////////
    // read port: data one cycle after the strobe, zero elsewhere

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= `MIC_RST_BYTE;
        end else if (bus_req.rd) begin
            if (shadow_hit(bus_req.addr)) begin
                rdata_q <= shadow_q[shadow_idx(bus_req.addr)]; // R10
            end else begin
                case (bus_req.addr)
                    `MIC_ADDR_CTRL:   rdata_q <= ctrl_q;
                    `MIC_ADDR_OPTION: rdata_q <= option_q;
                    `MIC_ADDR_PEN1:   rdata_q <= pen1_q;
                    `MIC_ADDR_PEN2:   rdata_q <= pen2_q;
                    `MIC_ADDR_PEN3:   rdata_q <= pen3_q;
                    `MIC_ADDR_PREQ1:  rdata_q <= preq1_q;
                    `MIC_ADDR_PREQ2:  rdata_q <= preq2_q;
                    `MIC_ADDR_PREQ3:  rdata_q <= preq3_q;
                    default:          rdata_q <= `MIC_RST_BYTE;
                endcase
            end
        end else begin
            rdata_q <= `MIC_RST_BYTE;
        end
    end

    assign bus_rdata = rdata_q;

endmodule

// file: tb/mic_irq_monitor.sv
/*
 * Concurrent checks on the controller ports.
 * Assumes one clock, async active-low reset, and binding onto mic_irq_ctrl.
 */
`timescale 1ns/1ps
`include "mic_irq_regs.svh"

module mic_irq_monitor
    import mic_irq_pkg::*;
(
    input wire logic         clk,
    input wire logic         nrst,
    input wire mic_bus_req_t bus_req,
    input wire logic [7:0]   bus_rdata,
    input wire logic         sleep_active,
    input wire logic         return_from_irq_op,
    input wire mic_ctx_t     core_ctx,
    input wire logic         flush_prefetch,
    input wire logic         stack_push,
    input wire logic         vector_load,
    input wire logic [14:0]  vector_addr,
    input wire logic         stack_pop,
    input wire logic         ctx_restore,
    input wire mic_ctx_t     restore_ctx,
    input wire logic         wake
);
    localparam logic [63:0] CAP_MASK = {48'hFFFF_FFFF_FFFF, `MIC_STATUS_SAVE_MASK, 8'hFF};
    logic [7:0] mask_q;

    ////////////////////////////////////////////////////////////////////////////
    // bits allowed in the read answer; zero also covers idle and unmapped
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask_q <= 8'h00;
        end else if (!bus_req.rd) begin
            mask_q <= 8'h00;
        end else begin
            case (bus_req.addr)
                `MIC_ADDR_CTRL, `MIC_ADDR_OPTION: mask_q <= 8'hFF;
                `MIC_ADDR_PEN1, `MIC_ADDR_PREQ1: mask_q <= `MIC_PMASK1;
                `MIC_ADDR_PEN2, `MIC_ADDR_PREQ2: mask_q <= `MIC_PMASK2;
                `MIC_ADDR_PEN3, `MIC_ADDR_PREQ3: mask_q <= `MIC_PMASK3;
                default: begin
                    mask_q <= ((bus_req.addr & `MIC_SHADOW_BASE_MASK) == `MIC_ADDR_SHADOW_BASE) ? 8'hFF : 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    take_trio_a: assert property (flush_prefetch == vector_load && stack_push == vector_load)
        else $error("take pulses disagree");
    vector_addr_a: assert property (vector_load |-> vector_addr == `MIC_VECTOR)
        else $error("wrong vector address");
    take_once_a: assert property (vector_load |=> !vector_load)
        else $error("second take pulse");
    ret_latency_a: assert property (return_from_irq_op |=> stack_pop && ctx_restore)
        else $error("return not answered");
    pop_cause_a: assert property (stack_pop |-> $past(return_from_irq_op))
        else $error("pop without return");
    shadow_capture_a: assert property (vector_load |=> ((restore_ctx ^ $past(core_ctx)) & CAP_MASK) == 64'h0)
        else $error("shadow copies miss context");
    status_mask_a: assert property ((restore_ctx.status & 8'h18) == 8'h00)
        else $error("status flags shadowed");
    sleep_hold_a: assert property ($past(sleep_active) |-> !vector_load ##1 !vector_load)
        else $error("vector too soon after sleep");
    wake_gate_a: assert property (wake |-> sleep_active)
        else $error("wake outside sleep");
    rdata_mask_a: assert property ((bus_rdata & ~mask_q) == 8'h00)
        else $error("unimplemented bits set");
endmodule

bind mic_irq_ctrl mic_irq_monitor i_mic_irq_monitor (.clk(clk), .nrst(nrst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .sleep_active(sleep_active), .return_from_irq_op(return_from_irq_op),
    .core_ctx(core_ctx), .flush_prefetch(flush_prefetch), .stack_push(stack_push),
    .vector_load(vector_load), .vector_addr(vector_addr), .stack_pop(stack_pop),
    .ctx_restore(ctx_restore), .restore_ctx(restore_ctx), .wake(wake));

// file: tb/mic_core_model.sv
/*
 * Behavioural core: walking context, sleep on request, return after a fixed routine.
 * Assumes the controller pulses vector_load once per entry.
 */
`timescale 1ns/1ps

module mic_core_model
    import mic_irq_pkg::*;
#(
    parameter int ISR_LEN = 16
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic vector_load,
    input  wire logic wake,
    input  wire logic sleep_req,
    output logic      sleep_active,
    output logic      return_from_irq_op,
    output mic_ctx_t  core_ctx
);
    int cnt_q;

    // context changes every cycle so an early or late capture shows
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            core_ctx <= 64'h0123_4567_89AB_CDEF;
        end else begin
            core_ctx <= {core_ctx[55:0], core_ctx[63:56] + 8'h3B};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sleep_active <= 1'b0;
        end else if (wake) begin
            sleep_active <= 1'b0;
        end else if (sleep_req) begin
            sleep_active <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 0;
        end else if (vector_load) begin
            cnt_q <= ISR_LEN;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign return_from_irq_op = (cnt_q == 1);
endmodule

// file: tb/tb_mcu_interrupt_controller.sv
/*
 * Self-checking bench: registers, flags, vectoring, sleep.
 * Assumes mic_core_model as the core and the bench as event source.
 */
`timescale 1ns/1ps
`include "mic_irq_regs.svh"

module tb_mcu_interrupt_controller;
    import mic_irq_pkg::*;
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    logic         ext_pin = 1'b0;
    logic         pin_change_any = 1'b0;
    logic         sleep_req = 1'b0;
    mic_bus_req_t bus_req = '0;
    mic_evt_t     evt = '0;
    logic [7:0]   bus_rdata;
    logic         sleep_active, ret_op, flush, push, vector_load, stack_pop, ctx_restore, wake;
    logic [14:0]  vector_addr;
    mic_ctx_t     core_ctx, restore_ctx;
    int           num_errors = 0;
    int           compares = 0;
    int           n;
    logic [7:0]   pa [8] = '{`MIC_ADDR_PEN3, `MIC_ADDR_PEN3, `MIC_ADDR_PEN2, `MIC_ADDR_PEN2,
                             `MIC_ADDR_PEN1, `MIC_ADDR_PEN1, `MIC_ADDR_PEN1, `MIC_ADDR_PEN1};
    logic [7:0]   pb [8] = '{8'h01, 8'h02, 8'h04, 8'h20, 8'h01, 8'h02, 8'h40, 8'h80};
    logic [7:0]   pm [8] = '{8'hFF, 8'hFF, `MIC_PMASK1, `MIC_PMASK2, `MIC_PMASK3,
                             `MIC_PMASK1, `MIC_PMASK2, `MIC_PMASK3};

    mic_irq_ctrl i_mic_irq_ctrl (.clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .evt(evt), .ext_pin(ext_pin), .pin_change_any(pin_change_any), .sleep_active(sleep_active),
        .return_from_irq_op(ret_op), .core_ctx(core_ctx), .flush_prefetch(flush), .stack_push(push),
        .vector_load(vector_load), .vector_addr(vector_addr), .stack_pop(stack_pop),
        .ctx_restore(ctx_restore), .restore_ctx(restore_ctx), .wake(wake));
    mic_core_model i_mic_core_model (.clk(clk), .nrst(nrst), .vector_load(vector_load), .wake(wake),
        .sleep_req(sleep_req), .sleep_active(sleep_active), .return_from_irq_op(ret_op),
        .core_ctx(core_ctx));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end

    task automatic summarize();
        $display("counts: %0d compares, %0d mismatches", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(bus_rdata, exp);
    endtask

    // counts cycles from the event cycle to the take; 0 means no take
    task automatic wait_take(output int c);
        c = 0;
        for (int i = 1; i <= 12 && c == 0; i++) begin
            @(posedge clk);
            evt <= '0;
            #1;
            if (vector_load === 1'b1) c = i;
        end
    endtask

    task automatic fire(input int b, output int c);
        @(posedge clk);
        evt <= mic_evt_t'(9'h001 << b);
        wait_take(c);
    endtask

    task automatic pin(input logic v, output int c);
        @(posedge clk);
        ext_pin <= v;
        wait_take(c);
    endtask

    task automatic doze();
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
    endtask

    // routine body: clear the source, then wait for the return
    task automatic service(input logic [7:0] a, input logic [7:0] d);
        wr(a, d);
        for (int i = 0; i < 40 && stack_pop !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk({7'h0, stack_pop}, 8'h01);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a < 8; a++) rd(8'(a), (a == 1) ? `MIC_RST_OPTION : 8'h00);
        rd(8'h20, 8'h00);
        for (int a = 2; a < 8; a++) begin
            wr(8'(a), 8'hFF);
            rd(8'(a), pm[a]);
            wr(8'(a), 8'h00);
        end
        wr(`MIC_ADDR_CTRL, 8'h7F);
        rd(`MIC_ADDR_CTRL, 8'h7E);
        wr(`MIC_ADDR_CTRL, 8'h00);
        $display("registers done");

        for (int b = 0; b < 9; b++) begin
            fire(b, n);
            chk(8'(n), 8'h00);
        end
        for (int a = 5; a < 8; a++) rd(8'(a), pm[a]);
        @(posedge clk);
        pin_change_any <= 1'b1;
        rd(`MIC_ADDR_CTRL, 8'h05);
        @(posedge clk);
        pin_change_any <= 1'b0;
        wr(`MIC_ADDR_CTRL, 8'h00);
        rd(`MIC_ADDR_CTRL, 8'h00);
        for (int a = 5; a < 8; a++) wr(8'(a), 8'h00);
        $display("flags done");

        wr(`MIC_ADDR_CTRL, 8'hC0);
        for (int b = 0; b < 8; b++) begin
            wr(pa[b], pb[b]);
            fire(b, n);
            chk(8'(n), 8'h02);
            service(pa[b] + 8'h03, 8'h00);
            wr(pa[b], 8'h00);
        end
        wr(`MIC_ADDR_CTRL, 8'h80);
        wr(`MIC_ADDR_PEN1, 8'h01);
        fire(4, n);
        chk(8'(n), 8'h00);
        wr(`MIC_ADDR_CTRL, 8'h40);
        wait_take(n);
        chk(8'(n), 8'h00);
        wr(`MIC_ADDR_CTRL, 8'hC0);
        wait_take(n);
        chk({7'h0, n != 0}, 8'h01);
        service(`MIC_ADDR_PREQ1, 8'h00);
        wr(`MIC_ADDR_PEN1, 8'h00);
        $display("vectoring done");

        wr(`MIC_ADDR_CTRL, 8'hA0);
        fire(8, n);
        chk(8'(n), 8'h02);
        wr(`MIC_ADDR_SHADOW_BASE, 8'h5A);
        rd(`MIC_ADDR_SHADOW_BASE, 8'h5A);
        service(`MIC_ADDR_CTRL, 8'h20);
        chk(restore_ctx.wreg, 8'h5A);
        rd(`MIC_ADDR_CTRL, 8'hA0);
        $display("shadow done");

        wr(`MIC_ADDR_CTRL, 8'h90);
        pin(1'b1, n);
        chk({7'h0, n >= 2 && n <= 4}, 8'h01);
        service(`MIC_ADDR_CTRL, 8'h10);
        pin(1'b0, n);
        chk(8'(n), 8'h00);
        rd(`MIC_ADDR_CTRL, 8'h90);
        wr(`MIC_ADDR_OPTION, 8'hBF);
        pin(1'b1, n);
        chk(8'(n), 8'h00);
        pin(1'b0, n);
        chk({7'h0, n >= 2 && n <= 4}, 8'h01);
        service(`MIC_ADDR_CTRL, 8'h10);
        $display("edge pin done");

        wr(`MIC_ADDR_PEN3, 8'h01);
        wr(`MIC_ADDR_CTRL, 8'h40);
        doze();
        fire(0, n);
        chk(8'(n), 8'h00);
        chk({7'h0, sleep_active}, 8'h00);
        wr(`MIC_ADDR_PREQ3, 8'h00);
        wr(`MIC_ADDR_CTRL, 8'hC0);
        doze();
        fire(0, n);
        chk(8'(n), 8'h04);
        service(`MIC_ADDR_PREQ3, 8'h00);
        $display("sleep done");

        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(`MIC_ADDR_CTRL, 8'h00);
        rd(`MIC_ADDR_PEN3, 8'h00);
        $display("second reset done");
        summarize();
    end
endmodule
